// ==== core/nce_alu.sv ====
/*
  4-bit ALU: opa + opb + cin, or opa - opb - !cin.
  For subtraction cout means no borrow. Assumes the core registers results.
*/
`timescale 1ns/1ps
`default_nettype none

module nce_alu
  import nce_pkg::*;
(
  nce_alu_if.alu alu
);

  logic [DATA_W:0] sum;

  // Subtract as add of complement, so carry out reads as no borrow
  always_comb begin
    if (alu.fn == ALU_SUB) begin
      sum = {1'b0, alu.opa} + {1'b0, ~alu.opb} + {4'h0, alu.cin};
    end else begin
      sum = {1'b0, alu.opa} + {1'b0, alu.opb} + {4'h0, alu.cin};
    end
    alu.res = sum[DATA_W-1:0];
    alu.cout = sum[DATA_W];
    alu.nz = |sum[DATA_W-1:0];
  end

endmodule : nce_alu

`default_nettype wire

// ==== core/nce_alu_if.sv ====
/*
  Interface between the execution core and its 4-bit ALU.
  Assumes a purely combinational ALU on the alu side.
*/
`timescale 1ns/1ps
`default_nettype none

interface nce_alu_if;
  import nce_pkg::*;

  nce_alu_fn_t fn;
  logic [DATA_W-1:0] opa;
  logic [DATA_W-1:0] opb;
  logic cin;
  logic [DATA_W-1:0] res;
  logic cout;
  logic nz;

  modport core (output fn, output opa, output opb, output cin, input res, input cout, input nz);
  modport alu (input fn, input opa, input opb, input cin, output res, output cout, output nz);
endinterface : nce_alu_if

`default_nettype wire

// ==== core/nce_exec.sv ====
/*
  Execution control of a 4-bit microcomputer core: clock division,
  status and carry flags, swaps, conditional flow, halt and reset.
  Assumes a decoder presents op class, operands and swap suffix
  synchronously, and RAM read data for address {x,y} during the cycle.
  // Function
  // RULE1 - Reset input during halt discards held state; normal initialisation follows.
  // RULE2 - Internal system clock is oscillator input divided by four.
  // RULE3 - All instructions take one cycle; pattern fetch takes exactly two.
  // RULE4 - Not-zero instructions set status when ALU result is nonzero.
  // RULE5 - Carry instructions set status when addition produces carry out.
  // RULE6 - No-borrow instructions set status when subtraction needs no borrow.
  // RULE7 - Test instructions copy named bit, pin or flag straight into status.
  // RULE8 - Only eight named instructions change the carry flag.
  // RULE9 - Swap suffix exchanges X, Y or both with spares after RAM access.
  // RULE10 - Subroutine call pushes return and jumps only when status is one.
  // RULE11 - Upper counter load replaces page bits only when status is one.
  // RULE12 - Status jump loads target only when status is one, else falls through.
  // RULE13 - Halt pin low freezes clock and all state; high resumes.
  // RULE14 - Status undefined after reset; firmware sets it before conditional flow.
*/
`timescale 1ns/1ps
`default_nettype none

module nce_exec
  import nce_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  input wire logic reset_pin,
  input wire logic halt_pin_n,
  // Instruction from decoder
  input wire nce_op_t instr_op,
  input wire logic [DATA_W-1:0] instr_imm,
  input wire logic [PAGE_W-1:0] instr_addr,
  input wire logic [1:0] instr_swap,
  input wire logic test_source,
  // RAM
  input wire logic [DATA_W-1:0] ram_rdata,
  output logic [DATA_W-1:0] ram_x_r,
  output logic [DATA_W-1:0] ram_y_r,
  output logic ram_wr_r,
  output logic [DATA_W-1:0] ram_wdata_r,
  // Program and pattern fetch
  output logic [PC_W-1:0] pc_r,
  output logic fetch_r,
  output logic pat_rd_r,
  output logic [PC_W-1:0] pat_addr_r,
  // Visible state
  output logic sys_clk_r,
  output logic [DATA_W-1:0] acc_r,
  output logic [DATA_W-1:0] b_r,
  output logic status_r,
  output logic carry_r,
  output logic halted_r
);
  nce_alu_if alu_bus ();
  nce_alu u_alu (
    .alu(alu_bus.alu)
  );
  logic [PHASE_W-1:0] phase_r, phase_nxt;
  logic [DATA_W-1:0] spx_r, spx_nxt, spy_r, spy_nxt;
  logic [DATA_W-1:0] x_nxt, y_nxt, acc_nxt, b_nxt, wdata_nxt;
  logic [PC_W-1:0] pc_nxt, pat_addr_nxt;
  logic [PC_W-1:0] stack_r [STACK_DEPTH];
  logic [PC_W-1:0] stack_nxt [STACK_DEPTH];
  logic status_nxt, carry_nxt, wr_nxt, fetch_nxt, pat_rd_nxt, sys_clk_nxt;
  logic pat_busy_r, pat_busy_nxt;
  logic run, tick;
  logic [PC_W-1:0] pc_inc;
  // Halt stops the divider itself, so nothing advances while low
  assign run = ce && halt_pin_n; // [RULE13]
  assign tick = run && (phase_r == PHASE_LAST); // [RULE2]
  assign pc_inc = pc_r + 12'h001;

  // ALU operand selection from the op class
  always_comb begin
    alu_bus.fn = ALU_ADD;
    alu_bus.opa = ram_rdata;
    alu_bus.opb = acc_r;
    alu_bus.cin = 1'b0;
    case (instr_op)
      OP_ADD_WITH_CARRY: alu_bus.cin = carry_r;
      OP_SUBTRACT_WITH_BORROW: begin
        alu_bus.fn = ALU_SUB;
        alu_bus.cin = carry_r;
      end
      OP_DECIMAL_ADJUST_ADD: begin
        alu_bus.opa = acc_r;
        alu_bus.opb = BCD_ADD_FIX;
      end
      OP_DECIMAL_ADJUST_SUBTRACT: begin
        alu_bus.opa = acc_r;
        alu_bus.opb = BCD_SUB_FIX;
      end
      OP_INC_Y: begin
        alu_bus.opa = ram_y_r;
        alu_bus.opb = 4'h1;
      end
      OP_MEM_NE_IMM: begin
        alu_bus.fn = ALU_SUB;
        alu_bus.opb = instr_imm;
        alu_bus.cin = 1'b1;
      end
      OP_ACC_LE_IMM: begin
        alu_bus.fn = ALU_SUB;
        alu_bus.opa = instr_imm;
        alu_bus.cin = 1'b1;
      end
      default: alu_bus.fn = ALU_ADD;
    endcase
  end

  // Next-state of the whole core; phase and system clock move on every running edge, the rest only on an instruction tick
  always_comb begin
    phase_nxt = phase_r;
    sys_clk_nxt = sys_clk_r;
    pc_nxt = pc_r;
    acc_nxt = acc_r;
    b_nxt = b_r;
    x_nxt = ram_x_r;
    y_nxt = ram_y_r;
    spx_nxt = spx_r;
    spy_nxt = spy_r;
    status_nxt = status_r;
    carry_nxt = carry_r;
    wr_nxt = 1'b0;
    wdata_nxt = ram_wdata_r;
    fetch_nxt = 1'b0;
    pat_rd_nxt = 1'b0;
    pat_addr_nxt = pat_addr_r;
    pat_busy_nxt = pat_busy_r;
    stack_nxt = stack_r;
    if (run) begin
      phase_nxt = phase_r + 2'h1; // [RULE2]
      sys_clk_nxt = phase_nxt[PHASE_W-1];
    end
    if (tick && pat_busy_r) begin // Second cycle of the pattern fetch
      pat_rd_nxt = 1'b1; // [RULE3]
      pat_busy_nxt = 1'b0;
      pc_nxt = pc_inc;
      fetch_nxt = 1'b1;
    end else if (tick) begin
      pc_nxt = pc_inc;
      fetch_nxt = 1'b1;
      case (instr_op)
        OP_LOAD_ACC_IMM: acc_nxt = instr_imm;
        OP_LOAD_B_IMM: b_nxt = instr_imm;
        OP_LOAD_X_IMM: x_nxt = instr_imm;
        OP_LOAD_Y_IMM: y_nxt = instr_imm;
        OP_LOAD_ACC_MEM: acc_nxt = ram_rdata;
        OP_STORE_ACC_MEM: begin
          wr_nxt = 1'b1;
          wdata_nxt = acc_r;
        end
        OP_INC_Y: begin
          y_nxt = alu_bus.res;
          status_nxt = alu_bus.nz; // [RULE4]
        end
        OP_ADD_MEM: begin
          acc_nxt = alu_bus.res;
          status_nxt = alu_bus.cout; // [RULE5]
        end
        OP_ADD_WITH_CARRY: begin
          acc_nxt = alu_bus.res;
          status_nxt = alu_bus.cout; // [RULE5]
          carry_nxt = alu_bus.cout; // [RULE8]
        end
        OP_SUBTRACT_WITH_BORROW: begin
          acc_nxt = alu_bus.res;
          status_nxt = alu_bus.cout; // [RULE6]
          carry_nxt = alu_bus.cout; // [RULE8]
        end
        OP_DECIMAL_ADJUST_ADD: begin
          // Only a digit above nine or a pending carry needs fixing
          if (carry_r || (acc_r > BCD_MAX)) begin
            acc_nxt = alu_bus.res;
            carry_nxt = 1'b1; // [RULE8]
          end
        end
        OP_DECIMAL_ADJUST_SUBTRACT: begin
          if (!carry_r) acc_nxt = alu_bus.res;
          carry_nxt = carry_r; // [RULE8]
        end
        OP_SET_CARRY: carry_nxt = 1'b1; // [RULE8]
        OP_CLEAR_CARRY_FLAG: carry_nxt = 1'b0; // [RULE8]
        OP_TEST_CARRY: status_nxt = carry_r; // [RULE7]
        OP_ROTATE_LEFT: begin
          acc_nxt = {acc_r[DATA_W-2:0], carry_r};
          carry_nxt = acc_r[DATA_W-1]; // [RULE8]
        end
        OP_ROTATE_RIGHT: begin
          acc_nxt = {carry_r, acc_r[DATA_W-1:1]};
          carry_nxt = acc_r[0]; // [RULE8]
        end
        OP_MEM_NE_IMM: status_nxt = alu_bus.nz; // [RULE4]
        OP_ACC_LE_IMM: status_nxt = alu_bus.cout; // [RULE6]
        OP_TEST_SOURCE: status_nxt = test_source; // [RULE7]
        OP_STATUS_JUMP: begin
          // Status is cleared to RESET_STATUS at reset; firmware sets it first [RULE14]
          if (status_r) begin
            pc_nxt = {pc_r[PC_W-1:PAGE_W], instr_addr}; // [RULE12]
          end
        end
        OP_CALL: begin
          if (status_r) begin
            stack_nxt[0] = pc_inc; // [RULE10]
            for (int i = 1; i < STACK_DEPTH; i++) begin
              stack_nxt[i] = stack_r[i-1];
            end
            pc_nxt = {pc_r[PC_W-1:PAGE_W], instr_addr}; // [RULE10]
          end
        end
        OP_RETURN: begin
          pc_nxt = stack_r[0];
          for (int i = 0; i < STACK_DEPTH - 1; i++) begin
            stack_nxt[i] = stack_r[i+1];
          end
        end
        OP_LOAD_UPPER_COUNTER_ON_STATUS: begin
          if (status_r) begin
            pc_nxt = {instr_addr, pc_inc[PAGE_W-1:0]}; // [RULE11]
          end
        end
        OP_PATTERN: begin
          // Hold the counter; it moves on after the second cycle
          pc_nxt = pc_r;
          fetch_nxt = 1'b0;
          pat_busy_nxt = 1'b1; // [RULE3]
          pat_addr_nxt = {pc_r[PC_W-1:2*DATA_W], b_r, acc_r};
        end
        default: pc_nxt = pc_inc;
      endcase
      // Swaps follow the main operation of RAM access only
      if (instr_op == OP_LOAD_ACC_MEM || instr_op == OP_STORE_ACC_MEM) begin
        if (instr_swap[SWAP_X_BIT]) begin
          x_nxt = spx_r; // [RULE9]
          spx_nxt = ram_x_r;
        end
        if (instr_swap[SWAP_Y_BIT]) begin
          y_nxt = spy_r; // [RULE9]
          spy_nxt = ram_y_r;
        end
      end
    end
  end

  // Register stage; reset pin wins over halt, so held state is lost
  always_ff @(posedge clk_sys) begin
    if (!nrst || reset_pin) begin // [RULE1]
      phase_r <= '0;
      sys_clk_r <= 1'b0;
      pc_r <= RESET_PC;
      acc_r <= RESET_NIBBLE;
      b_r <= RESET_NIBBLE;
      ram_x_r <= RESET_NIBBLE;
      ram_y_r <= RESET_NIBBLE;
      spx_r <= RESET_NIBBLE;
      spy_r <= RESET_NIBBLE;
      status_r <= RESET_STATUS;
      carry_r <= RESET_CARRY;
      ram_wr_r <= 1'b0;
      ram_wdata_r <= RESET_NIBBLE;
      fetch_r <= 1'b0;
      pat_rd_r <= 1'b0;
      pat_addr_r <= '0;
      pat_busy_r <= 1'b0;
      halted_r <= 1'b0;
      stack_r <= '{default: '0};
    end else if (ce) begin
      phase_r <= phase_nxt;
      sys_clk_r <= sys_clk_nxt;
      pc_r <= pc_nxt;
      acc_r <= acc_nxt;
      b_r <= b_nxt;
      ram_x_r <= x_nxt;
      ram_y_r <= y_nxt;
      spx_r <= spx_nxt;
      spy_r <= spy_nxt;
      status_r <= status_nxt;
      carry_r <= carry_nxt;
      ram_wr_r <= wr_nxt;
      ram_wdata_r <= wdata_nxt;
      fetch_r <= fetch_nxt;
      pat_rd_r <= pat_rd_nxt;
      pat_addr_r <= pat_addr_nxt;
      pat_busy_r <= pat_busy_nxt;
      halted_r <= !halt_pin_n; // [RULE13]
      stack_r <= stack_nxt;
    end
  end

endmodule : nce_exec

`default_nettype wire

// ==== core/nce_pkg.sv ====
/*
  Shared constants and types of the nibble execution-control core:
  opcode classes, ALU functions, widths, reset values and the divider.
  Assumes an outside decoder that turns instruction words into op classes.
*/
package nce_pkg;

  // Widths
  localparam int DATA_W = 4;
  localparam int PC_W = 12;
  localparam int PAGE_W = 6;
  localparam int STACK_DEPTH = 4;

  // Oscillator to system clock division
  localparam int DIV_RATIO = 4;
  localparam int PHASE_W = 2;
  localparam logic [PHASE_W-1:0] PHASE_LAST = PHASE_W'(DIV_RATIO - 1);

  // Reset values
  localparam logic [PC_W-1:0] RESET_PC = 12'hfff;
  localparam logic [DATA_W-1:0] RESET_NIBBLE = 4'h0;
  localparam logic RESET_STATUS = 1'b0;
  localparam logic RESET_CARRY = 1'b0;

  // Decimal adjust figures
  localparam logic [DATA_W-1:0] BCD_MAX = 4'h9;
  localparam logic [DATA_W-1:0] BCD_ADD_FIX = 4'h6;
  localparam logic [DATA_W-1:0] BCD_SUB_FIX = 4'ha;

  // Swap suffix bits
  localparam int SWAP_X_BIT = 1;
  localparam int SWAP_Y_BIT = 0;

  typedef enum logic [4:0] {
    OP_NOP,
    OP_LOAD_ACC_IMM,
    OP_LOAD_B_IMM,
    OP_LOAD_X_IMM,
    OP_LOAD_Y_IMM,
    OP_LOAD_ACC_MEM,
    OP_STORE_ACC_MEM,
    OP_INC_Y,
    OP_ADD_MEM,
    OP_ADD_WITH_CARRY,
    OP_SUBTRACT_WITH_BORROW,
    OP_DECIMAL_ADJUST_ADD,
    OP_DECIMAL_ADJUST_SUBTRACT,
    OP_SET_CARRY,
    OP_CLEAR_CARRY_FLAG,
    OP_TEST_CARRY,
    OP_ROTATE_LEFT,
    OP_ROTATE_RIGHT,
    OP_MEM_NE_IMM,
    OP_ACC_LE_IMM,
    OP_TEST_SOURCE,
    OP_STATUS_JUMP,
    OP_CALL,
    OP_RETURN,
    OP_LOAD_UPPER_COUNTER_ON_STATUS,
    OP_PATTERN
  } nce_op_t;

  typedef enum logic {
    ALU_ADD,
    ALU_SUB
  } nce_alu_fn_t;

endpackage : nce_pkg

// ==== verif/nce_exec_chk.sv ====
/* Checker of nce_exec port timing.
   Assumes one clock domain and the bind at the foot. */
`timescale 1ns/1ps
`default_nettype none
module nce_exec_chk
  import nce_pkg::*;
(
  // Clock, reset and control
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  input wire logic reset_pin,
  input wire logic halt_pin_n,
  // Instruction
  input wire nce_op_t instr_op,
  input wire logic [PAGE_W-1:0] instr_addr,
  input wire logic test_source,
  // Watched state
  input wire logic [PC_W-1:0] pc_r,
  input wire logic fetch_r,
  input wire logic pat_rd_r,
  input wire logic [PC_W-1:0] pat_addr_r,
  input wire logic sys_clk_r,
  input wire logic [DATA_W-1:0] acc_r,
  input wire logic [DATA_W-1:0] b_r,
  input wire logic status_r,
  input wire logic carry_r
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // Running edge, page and next address helpers
  wire run = ce && halt_pin_n && !reset_pin;
  wire [PAGE_W-1:0] pg = pc_r[PC_W-1:PAGE_W];
  wire [PC_W-1:0] pc_inc = pc_r + 12'h001;
  wire [PAGE_W-1:0] inc_lo = pc_inc[PAGE_W-1:0];
  // Tick follows a completion by three running edges
  sequence s_tick;
    fetch_r && run ##1 run [*3];
  endsequence
  a_reset_init: assert property (reset_pin |=> pc_r == RESET_PC && acc_r == RESET_NIBBLE && !carry_r)
    else $error("reset pin did not restore initial state");
  a_halt_hold: assert property (!halt_pin_n && !reset_pin |=> $stable(pc_r) && $stable(acc_r)
    && $stable(carry_r) && $stable(status_r)) else $error("state moved while halted");
  a_clk_div4: assert property (run [*4] |=> sys_clk_r == !$past(sys_clk_r, 2))
    else $error("system clock not oscillator over four");
  a_pattern_two: assert property (s_tick ##0 instr_op == OP_PATTERN |=> (!fetch_r && run
    && pat_addr_r == {pc_r[PC_W-1:8], b_r, acc_r} ##1 run [*3] |=> fetch_r && pat_rd_r))
    else $error("pattern fetch not two cycles");
  a_jump_cond: assert property (s_tick ##0 instr_op == OP_STATUS_JUMP |=> pc_r == ($past(status_r) ?
    {$past(pg), $past(instr_addr)} : $past(pc_inc))) else $error("status jump wrong target");
  a_upper_cond: assert property (s_tick ##0 instr_op == OP_LOAD_UPPER_COUNTER_ON_STATUS |=> pc_r ==
    ($past(status_r) ? {$past(instr_addr), $past(inc_lo)} : $past(pc_inc))) else $error("upper load wrong");
  a_carry_eight: assert property (s_tick ##0 !(instr_op inside {OP_ADD_WITH_CARRY,
    OP_SUBTRACT_WITH_BORROW, OP_DECIMAL_ADJUST_ADD, OP_DECIMAL_ADJUST_SUBTRACT, OP_SET_CARRY, OP_CLEAR_CARRY_FLAG,
    OP_ROTATE_LEFT, OP_ROTATE_RIGHT}) |=> $stable(carry_r)) else $error("carry changed by other op");
  a_test_copy: assert property (s_tick ##0 instr_op == OP_TEST_SOURCE |=> status_r == $past(test_source))
    else $error("test source not copied");
endmodule : nce_exec_chk

bind nce_exec nce_exec_chk u_chk (.clk_sys(clk_sys), .nrst(nrst), .ce(ce), .reset_pin(reset_pin),
  .halt_pin_n(halt_pin_n), .instr_op(instr_op), .instr_addr(instr_addr), .test_source(test_source),
  .pc_r(pc_r), .fetch_r(fetch_r), .pat_rd_r(pat_rd_r), .pat_addr_r(pat_addr_r), .sys_clk_r(sys_clk_r),
  .acc_r(acc_r), .b_r(b_r), .status_r(status_r), .carry_r(carry_r));
`default_nettype wire

// ==== verif/test_nce_exec.sv ====
/* Self-checking bench of nce_exec with a reference model.
   Assumes the checker binds itself. */
`timescale 1ns/1ps
`default_nettype none
module test_nce_exec;
  import nce_pkg::*;
  // Design pins
  logic clk_sys, nrst, ce, reset_pin, halt_pin_n, test_source, ram_wr_r, fetch_r, pat_rd_r, sys_clk_r;
  logic status_r, carry_r, halted_r;
  nce_op_t instr_op;
  logic [3:0] instr_imm, ram_rdata, ram_x_r, ram_y_r, ram_wdata_r, acc_r, b_r;
  logic [5:0] instr_addr;
  logic [1:0] instr_swap;
  logic [11:0] pc_r, pat_addr_r;
  // Model and bookkeeping
  logic [11:0] m_pc;
  logic [3:0] m_a, m_b, m_x, m_y, m_sx, m_sy;
  logic m_c, m_s;
  logic [11:0] stk[$];
  int err_count, cmp_count, seed, cyc, n;
  nce_op_t ops[20] = '{OP_LOAD_ACC_IMM, OP_LOAD_B_IMM, OP_ADD_MEM, OP_ADD_WITH_CARRY, OP_SUBTRACT_WITH_BORROW,
    OP_DECIMAL_ADJUST_ADD, OP_DECIMAL_ADJUST_SUBTRACT, OP_SET_CARRY, OP_CLEAR_CARRY_FLAG, OP_TEST_CARRY,
    OP_ROTATE_LEFT, OP_ROTATE_RIGHT, OP_MEM_NE_IMM, OP_ACC_LE_IMM, OP_TEST_SOURCE, OP_LOAD_X_IMM,
    OP_LOAD_Y_IMM, OP_LOAD_ACC_MEM, OP_STORE_ACC_MEM, OP_INC_Y};

  nce_exec uut (.clk_sys(clk_sys), .nrst(nrst), .ce(ce), .reset_pin(reset_pin), .halt_pin_n(halt_pin_n),
    .instr_op(instr_op), .instr_imm(instr_imm), .instr_addr(instr_addr), .instr_swap(instr_swap),
    .test_source(test_source), .ram_rdata(ram_rdata), .ram_x_r(ram_x_r), .ram_y_r(ram_y_r),
    .ram_wr_r(ram_wr_r), .ram_wdata_r(ram_wdata_r), .pc_r(pc_r), .fetch_r(fetch_r), .pat_rd_r(pat_rd_r),
    .pat_addr_r(pat_addr_r), .sys_clk_r(sys_clk_r), .acc_r(acc_r), .b_r(b_r), .status_r(status_r),
    .carry_r(carry_r), .halted_r(halted_r));

  // 10 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Hang guard, far above the planned run
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      end_of_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic init_m();
    m_pc = RESET_PC;
    {m_a, m_b, m_x, m_y, m_sx, m_sy, m_c, m_s} = '0;
    stk.delete();
  endtask : init_m

  // One instruction: predict, wait for completion, compare
  task automatic step(input nce_op_t op, input logic [3:0] imm, input logic [3:0] rd, input int en);
    logic [4:0] t;
    logic [11:0] nx;
    logic [11:0] pa;
    logic sv;
    instr_op = op;
    instr_imm = imm;
    ram_rdata = rd;
    sv = 1'b1;
    nx = m_pc + 12'h001;
    pa = {m_pc[11:8], m_b, m_a};
    case (op)
      OP_ADD_MEM: begin t = rd + m_a; m_a = t[3:0]; m_s = t[4]; end
      OP_INC_Y: begin m_y = m_y + 4'h1; m_s = m_y != 4'h0; end
      OP_ADD_WITH_CARRY: begin t = rd + m_a + m_c; {m_c, m_a} = t; m_s = t[4]; end
      OP_SUBTRACT_WITH_BORROW: begin t = {1'b1, rd} - m_a - !m_c; m_a = t[3:0]; m_c = t[4]; m_s = t[4]; end
      OP_TEST_CARRY: m_s = m_c;
      OP_MEM_NE_IMM: m_s = rd != imm;
      OP_ACC_LE_IMM: m_s = m_a <= imm;
      OP_TEST_SOURCE: m_s = test_source;
      OP_STATUS_JUMP: if (m_s) nx = {m_pc[11:6], instr_addr};
      OP_CALL: if (m_s) begin stk.push_back(nx); nx = {m_pc[11:6], instr_addr}; end
      OP_RETURN: nx = (stk.size() > 0) ? stk.pop_back() : 12'h000;
      OP_LOAD_UPPER_COUNTER_ON_STATUS: if (m_s) nx = {instr_addr, nx[5:0]};
      default: sv = 1'b0;
    endcase
    case (op)
      OP_LOAD_ACC_IMM: m_a = imm;
      OP_LOAD_B_IMM: m_b = imm;
      OP_LOAD_X_IMM: m_x = imm;
      OP_LOAD_Y_IMM: m_y = imm;
      OP_LOAD_ACC_MEM: m_a = rd;
      OP_DECIMAL_ADJUST_ADD: if (m_c || m_a > 4'h9) begin m_a = m_a + 4'h6; m_c = 1'b1; end
      OP_DECIMAL_ADJUST_SUBTRACT: if (!m_c) m_a = m_a + 4'ha;
      OP_SET_CARRY: m_c = 1'b1;
      OP_CLEAR_CARRY_FLAG: m_c = 1'b0;
      OP_ROTATE_LEFT: {m_c, m_a} = {m_a, m_c};
      OP_ROTATE_RIGHT: {m_a, m_c} = {m_c, m_a};
      default: ;
    endcase
    if (op inside {OP_LOAD_ACC_MEM, OP_STORE_ACC_MEM}) begin
      if (instr_swap[1]) {m_x, m_sx} = {m_sx, m_x};
      if (instr_swap[0]) {m_y, m_sy} = {m_sy, m_y};
    end
    m_pc = nx;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (fetch_r !== 1'b1 && n < 12);
    if (en > 0) chk("cycles", n, en);
    chk("pc", pc_r, m_pc);
    chk("acc", acc_r, m_a);
    chk("carry", carry_r, m_c);
    if (sv) chk("status", status_r, m_s);
    chk("xy", {ram_x_r, ram_y_r}, {m_x, m_y});
    chk("wr", ram_wr_r, op == OP_STORE_ACC_MEM);
    if (op == OP_STORE_ACC_MEM) chk("wdata", ram_wdata_r, m_a);
    if (op == OP_PATTERN) chk("pat", {pat_rd_r, pat_addr_r}, {1'b1, pa});
  endtask : step

  task automatic end_of_test();
    if (err_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test

  // Main sequence
  initial begin
    {err_count, cmp_count, cyc} = '0;
    seed = 67129;
    {nrst, reset_pin, test_source, instr_imm, instr_addr, instr_swap, ram_rdata} = '0;
    {ce, halt_pin_n} = 2'b11;
    instr_op = OP_NOP;
    repeat (8) @(negedge clk_sys);
    nrst = 1'b1;
    init_m();
    step(OP_LOAD_ACC_IMM, 4'h9, 4'h0, 4);
    // Random flag, carry and swap traffic
    for (int i = 0; i < 200; i++) begin
      test_source = 1'($random(seed));
      instr_swap = 2'($random(seed));
      step(ops[$unsigned($random(seed)) % 20], 4'($random(seed)), 4'($random(seed)), 4);
    end
    // Conditional flow both ways, then a pattern fetch
    for (int i = 0; i < 8; i++) begin
      test_source = 1'($random(seed));
      instr_addr = 6'($random(seed));
      step(OP_TEST_SOURCE, 4'h0, 4'h0, 4);
      step(OP_STATUS_JUMP, 4'h0, 4'h0, 4);
      step(OP_LOAD_UPPER_COUNTER_ON_STATUS, 4'h0, 4'h0, 4);
      step(OP_CALL, 4'h0, 4'h0, 4);
      step(OP_RETURN, 4'h0, 4'h0, 4);
      step(OP_PATTERN, 4'h0, 4'h0, 8);
    end
    // Halt and clock-enable freezes keep state and phase
    for (int i = 0; i < 2; i++) begin
      {ce, halt_pin_n} = i ? 2'b01 : 2'b10;
      repeat (20) @(negedge clk_sys);
      chk("halted", halted_r, i == 0);
      {ce, halt_pin_n} = 2'b11;
      step(OP_SET_CARRY, 4'h0, 4'h0, 4);
    end
    // Reset pin while halted discards the held state
    halt_pin_n = 1'b0;
    repeat (3) @(negedge clk_sys);
    chk("halted", halted_r, 1'b1);
    reset_pin = 1'b1;
    repeat (2) @(negedge clk_sys);
    reset_pin = 1'b0;
    halt_pin_n = 1'b1;
    init_m();
    chk("reset", {pc_r, acc_r, carry_r, halted_r}, {m_pc, m_a, m_c, 1'b0});
    step(OP_TEST_CARRY, 4'h0, 4'h0, 4);
    end_of_test();
  end
endmodule : test_nce_exec
`default_nettype wire
